/* File: usb_port_fault_supervisor_params.svh */
/*
  Constants for the USB port fault supervisor: timing counts, counter widths and the
  number of blanking timers. It assumes a 100 MHz system clock.
*/
// Summary of operation
// - Data-line overvoltage opens all switches at once and starts blanking, fault stays high.
// - Data-line overvoltage still present after blanking pulls the fault output low.
// - When data-line overvoltage ends, fault clears at once and soft-start begins.
// - Logic supply overvoltage cuts external and data switches; fault only after blanking.
// - Overcurrent regulates at the limit and starts blanking with fault released.
// - Current regulation lasts until blanking expires, overcurrent ends or a thermal fault appears.
// - Overcurrent past blanking asserts fault, enters autoretry, sources small current.
// - In autoretry, output above recovery level for blanking restores the channel.
// - Fast bus undervoltage opens the internal switch and starts blanking, fault high.
// - Undervoltage past blanking asserts fault; its end clears fault and soft-starts.
// - Supply lockout opens all switches and resets all logic except the input synchroniser.
// - Overtemperature cuts all switches and asserts fault at once until it cools.
// - Limit-set pin error opens all switches, asserts fault, clears when error ends.
// - Fault indication is an active-low open-drain output pulled low on faults.
// - With charge config low, enable closes power and data switches; disable opens.
// - Enable polarity is fixed per variant, active-high or active-low.
// - Plain enabled mode passes data through and keeps charger detection disabled.
`ifndef USB_PORT_FAULT_SUPERVISOR_PARAMS_SVH
`define USB_PORT_FAULT_SUPERVISOR_PARAMS_SVH

`define CLOCK_MHZ          100
`define BLANK_TIME_MS      20
`define BLANK_CYCLES       (`BLANK_TIME_MS * 1000 * `CLOCK_MHZ)
`define SOFT_START_TIME_US 10
`define SOFT_START_CYCLES  (`SOFT_START_TIME_US * `CLOCK_MHZ)
`define TIMER_W            24
`define SOFT_W             12
`define NUM_TIMERS         5
`define SYNC_W             11

`define T_OV_DATA  0
`define T_OV_LOGIC 1
`define T_OVERCUR  2
`define T_UNDERV   3
`define T_RECOVER  4

`endif

/* File: usb_port_fault_pkg.sv */
/*
  Types shared by the fault supervisor modules. Assumes nothing of its surroundings.
*/
`default_nettype none
package usb_port_fault_pkg;
  typedef enum logic [1:0] {
    OC_NORMAL = 2'b00,
    OC_LIMIT  = 2'b01,
    OC_RETRY  = 2'b10
  } oc_state_t;
endpackage
`default_nettype wire

/* File: blank_if.sv */
/*
  Carrier between the supervisor and its blanking timer bank: one condition and one
  expiry flag for each timer. Assumes both ends share the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "usb_port_fault_supervisor_params.svh"
interface blank_if;
  logic [`NUM_TIMERS-1:0] cond;
  logic [`NUM_TIMERS-1:0] expired;
  modport timer (input cond, output expired);
  modport user  (output cond, input expired);
endinterface
`default_nettype wire

/* File: input_sync.sv */
/*
  Two flip-flop synchroniser for a vector of asynchronous comparator and pin levels.
  Assumes each bit is a slow level, so bits may settle a cycle apart.
*/
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // The first stage is read by the second stage only.
  always_ff @(posedge clock) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // input_sync
`default_nettype wire

/* File: blanking_timer.sv */
/*
  Bank of blanking counters. Each counts while its condition holds, restarts from zero
  whenever the condition drops, and flags expiry after the given number of cycles.
  Assumes the conditions are synchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "usb_port_fault_supervisor_params.svh"
module blanking_timer #(
  parameter int LIMIT = `BLANK_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  blank_if.timer    bus
);
  localparam logic [`TIMER_W-1:0] LIMIT_W = `TIMER_W'(LIMIT);

  logic [`TIMER_W-1:0] count [`NUM_TIMERS];

  for (genvar i = 0; i < `NUM_TIMERS; i++) begin : g_timer
    // The counter saturates at the limit so expiry stays up while the condition does.
    always_ff @(posedge clock) begin
      if (rst || !bus.cond[i]) begin
        count[i] <= '0;
      end else if (count[i] != LIMIT_W) begin
        count[i] <= count[i] + `TIMER_W'(1);
      end
    end

    assign bus.expired[i] = (count[i] == LIMIT_W);

    a_count_restart : assert property (@(posedge clock) disable iff (rst)
      !bus.cond[i] |=> count[i] == '0)
      else $error("Blanking count did not restart after condition cleared.");

    a_count_step : assert property (@(posedge clock) disable iff (rst)
      bus.cond[i] && !bus.expired[i] |=> count[i] == $past(count[i]) + `TIMER_W'(1))
      else $error("Blanking count did not advance while condition held.");
  end
endmodule // blanking_timer
`default_nettype wire

/* File: usb_port_fault_supervisor.sv */
/*
  Fault supervisor and switch controller for a protected USB port. Comparator flags
  are qualified with blanking timers and drive the power switches, data switches,
  soft-start, autoretry and the open-drain fault output.
  Assumes analog comparators give level flags (the overtemperature flag carries its
  own thermal hysteresis), and that the host drives enable and charge config as levels.
*/
`timescale 1ns/10ps
`default_nettype none
`include "usb_port_fault_supervisor_params.svh"
module usb_port_fault_supervisor
  import usb_port_fault_pkg::*;
#(
  parameter bit ENABLE_ACTIVE_LOW = 1'b0,
  parameter int BLANK_CYCLES      = `BLANK_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ov_data_pos,
  input  wire logic ov_data_neg,
  input  wire logic ov_logic_supply,
  input  wire logic over_current,
  input  wire logic bus_undervolt,
  input  wire logic supply_lockout,
  input  wire logic over_temp,
  input  wire logic limit_set_error,
  input  wire logic out_above_recovery,
  input  wire logic enable_in,
  input  wire logic charge_cfg_bit1,
  input  wire logic fault_pin_in,
  output var  logic fault_pin_out,
  output var  logic fault_pin_oe_n,
  output var  logic ext_switch_on,
  output var  logic int_switch_on,
  output var  logic data_switch_on,
  output var  logic current_limit_active,
  output var  logic small_source_on,
  output var  logic soft_start,
  output var  logic charge_detect_enable
);
  localparam logic [`SOFT_W-1:0] SOFT_LAST = `SOFT_W'(`SOFT_START_CYCLES - 1);

  logic                ov_data;
  logic                ov_logic;
  logic                overcur;
  logic                underv;
  logic                lockout;
  logic                hot;
  logic                set_err;
  logic                recover_lvl;
  logic                en_raw;
  logic                cfg;
  logic                fault_pin_seen;
  logic                logic_rst;
  logic                en_active;
  logic                power_req;
  logic                data_req;
  logic                all_off;
  logic                any_fault;
  logic                ov_data_prev;
  logic                underv_prev;
  logic                soft_trigger;
  logic [`SOFT_W-1:0]  soft_count;
  oc_state_t           oc_state;
  oc_state_t           next_oc_state;

  blank_if blank ();

  // Every pin and comparator level is brought into the clock domain first.
  input_sync #(
    .WIDTH (`SYNC_W)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({ov_data_pos | ov_data_neg, ov_logic_supply, over_current, bus_undervolt,
             supply_lockout, over_temp, limit_set_error, out_above_recovery,
             enable_in, charge_cfg_bit1, fault_pin_in}),
    .q     ({ov_data, ov_logic, overcur, underv, lockout, hot, set_err, recover_lvl,
             en_raw, cfg, fault_pin_seen})
  );

  // Lockout acts as a reset of all supervisor state except the input synchroniser, not only of the switches.
  assign logic_rst = rst | lockout;

  blanking_timer #(
    .LIMIT (BLANK_CYCLES)
  ) u_timer (
    .clock (clock),
    .rst   (logic_rst),
    .bus   (blank)
  );

  // Each timer runs only while its own condition holds.
  assign blank.cond[`T_OV_DATA]  = ov_data;
  assign blank.cond[`T_OV_LOGIC] = ov_logic;
  assign blank.cond[`T_OVERCUR]  = overcur && (oc_state == OC_LIMIT);
  assign blank.cond[`T_UNDERV]   = underv;
  assign blank.cond[`T_RECOVER]  = recover_lvl && (oc_state == OC_RETRY);

  // Polarity is a build-time choice; all else is identical between variants.
  assign en_active = ENABLE_ACTIVE_LOW ? !en_raw : en_raw;

  // Charge config high selects charging modes, which keep bus power on but hold the
  // data path open here because their switch steering lives elsewhere.
  assign power_req = en_active | cfg;
  assign data_req  = en_active & !cfg;

  // Conditions that open every power and data switch at once.
  assign all_off = ov_data | set_err;

  // A fault is qualified when blanking has expired or the event needs no blanking.
  assign any_fault = (ov_data && blank.expired[`T_OV_DATA])
                   | (ov_logic && blank.expired[`T_OV_LOGIC])
                   | (oc_state == OC_RETRY)
                   | (underv && blank.expired[`T_UNDERV])
                   | hot
                   | set_err;

  // Overcurrent sequence: limit during blanking, then autoretry until recovery.
  always_comb begin
    next_oc_state = oc_state;
    unique case (oc_state)
      OC_NORMAL: begin
        if (overcur && !hot) begin
          next_oc_state = OC_LIMIT;
        end
      end
      OC_LIMIT: begin
        if (hot || !overcur) begin
          next_oc_state = OC_NORMAL;
        end else if (blank.expired[`T_OVERCUR]) begin
          next_oc_state = OC_RETRY;
        end
      end
      OC_RETRY: begin
        if (blank.expired[`T_RECOVER]) begin
          next_oc_state = OC_NORMAL;
        end
      end
      default: begin
        next_oc_state = OC_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (logic_rst) begin
      oc_state <= OC_NORMAL;
    end else begin
      oc_state <= next_oc_state;
    end
  end

  // Edge history for the fault removals that lead into soft-start.
  always_ff @(posedge clock) begin
    if (logic_rst) begin
      ov_data_prev <= 1'b0;
      underv_prev  <= 1'b0;
    end else begin
      ov_data_prev <= ov_data;
      underv_prev  <= underv;
    end
  end

  assign soft_trigger = (ov_data_prev && !ov_data) || (underv_prev && !underv);

  // Soft-start holds for a fixed ramp time; a new removal restarts the ramp.
  always_ff @(posedge clock) begin
    if (logic_rst) begin
      soft_start <= 1'b0;
      soft_count <= '0;
    end else if (soft_trigger) begin
      soft_start <= 1'b1;
      soft_count <= '0;
    end else if (soft_start) begin
      soft_count <= soft_count + `SOFT_W'(1);
      if (soft_count == SOFT_LAST) begin
        soft_start <= 1'b0;
      end
    end
  end

  // Fault pin: the output level is fixed low, only the enable toggles.
  always_ff @(posedge clock) begin
    if (logic_rst) begin
      fault_pin_out  <= 1'b0;
      fault_pin_oe_n <= 1'b1;
    end else begin
      fault_pin_out  <= 1'b0;
      fault_pin_oe_n <= !any_fault;
    end
  end

  // Switch drive; the fault conditions except overcurrent, which waits for autoretry, override the host request immediately.
  always_ff @(posedge clock) begin
    if (logic_rst) begin
      ext_switch_on  <= 1'b0;
      int_switch_on  <= 1'b0;
      data_switch_on <= 1'b0;
    end else begin
      ext_switch_on  <= power_req && !all_off && !ov_logic && !hot;
      int_switch_on  <= power_req && !all_off && !underv && !hot &&
                        (next_oc_state != OC_RETRY);
      data_switch_on <= data_req && !all_off && !ov_logic && !hot;
    end
  end

  // Current-limit and retry source flags follow the overcurrent state directly.
  always_ff @(posedge clock) begin
    if (logic_rst) begin
      current_limit_active <= 1'b0;
      small_source_on      <= 1'b0;
      charge_detect_enable <= 1'b0;
    end else begin
      current_limit_active <= (next_oc_state == OC_LIMIT);
      small_source_on      <= (next_oc_state == OC_RETRY);
      charge_detect_enable <= en_active && cfg;
    end
  end

  a_data_ov_off : assert property (@(posedge clock) disable iff (logic_rst)
    ov_data |=> !ext_switch_on && !int_switch_on && !data_switch_on)
    else $error("Switches stayed closed during data-line overvoltage.");

  a_data_ov_fault : assert property (@(posedge clock) disable iff (logic_rst)
    ov_data && blank.expired[`T_OV_DATA] |=> !fault_pin_oe_n)
    else $error("Fault not asserted after data-line overvoltage blanking.");

  a_data_ov_soft : assert property (@(posedge clock) disable iff (logic_rst)
    $fell(ov_data) |=> soft_start)
    else $error("Soft-start did not follow removal of data-line overvoltage.");

  a_logic_ov_off : assert property (@(posedge clock) disable iff (logic_rst)
    ov_logic |=> !ext_switch_on && !data_switch_on)
    else $error("Switches stayed closed during logic supply overvoltage.");

  a_limit_entry : assert property (@(posedge clock) disable iff (logic_rst)
    oc_state == OC_NORMAL && overcur && !hot |=> current_limit_active && oc_state == OC_LIMIT)
    else $error("Current limiting did not start on overcurrent.");

  a_retry_entry : assert property (@(posedge clock) disable iff (logic_rst)
    oc_state == OC_LIMIT && overcur && !hot && blank.expired[`T_OVERCUR]
    |=> small_source_on && !int_switch_on ##1 !fault_pin_oe_n)
    else $error("Autoretry not entered after overcurrent blanking.");

  a_retry_exit : assert property (@(posedge clock) disable iff (logic_rst)
    oc_state == OC_RETRY && blank.expired[`T_RECOVER] |=> oc_state == OC_NORMAL && !small_source_on)
    else $error("Channel did not recover after output stayed above threshold.");

  a_uv_off : assert property (@(posedge clock) disable iff (logic_rst)
    underv |=> !int_switch_on)
    else $error("Internal switch closed during bus undervoltage.");

  a_temp_fault : assert property (@(posedge clock) disable iff (logic_rst)
    hot |=> !fault_pin_oe_n && !ext_switch_on && !int_switch_on && !data_switch_on)
    else $error("Overtemperature did not shut switches and assert fault.");

  a_limit_set_pin_fault : assert property (@(posedge clock) disable iff (logic_rst)
    set_err |=> !fault_pin_oe_n && !ext_switch_on && !data_switch_on)
    else $error("Limit-set error did not open switches and assert fault.");

  a_fault_cause : assert property (@(posedge clock) disable iff (logic_rst)
    !fault_pin_oe_n |-> $past(any_fault))
    else $error("Fault pin driven low without a qualified fault.");

  a_enable_path : assert property (@(posedge clock) disable iff (logic_rst)
    en_active && !cfg && !all_off && !ov_logic && !hot |=> data_switch_on && ext_switch_on)
    else $error("Enable did not close the power and data switches.");

  // The fault node stays released while a lone data-line overvoltage is still blanked.
  a_data_ov_quiet : assert property (@(posedge clock) disable iff (logic_rst)
    ov_data && !blank.expired[`T_OV_DATA] && !hot && !set_err && !ov_logic && !underv &&
    oc_state != OC_RETRY |=> fault_pin_oe_n)
    else $error("Fault asserted during data-line overvoltage blanking.");

  a_data_ov_clear : assert property (@(posedge clock) disable iff (logic_rst)
    $fell(ov_data) && !hot && !set_err && !ov_logic && !underv && oc_state != OC_RETRY
    |=> fault_pin_oe_n)
    else $error("Fault not released when data-line overvoltage ended.");

  a_logic_ov_fault : assert property (@(posedge clock) disable iff (logic_rst)
    ov_logic && blank.expired[`T_OV_LOGIC] |=> !fault_pin_oe_n)
    else $error("Fault not asserted after logic supply overvoltage blanking.");

  a_thermal_abort : assert property (@(posedge clock) disable iff (logic_rst)
    oc_state == OC_LIMIT && hot |=> oc_state == OC_NORMAL && !current_limit_active)
    else $error("Current limiting continued through a thermal fault.");

  a_uv_fault : assert property (@(posedge clock) disable iff (logic_rst)
    underv && blank.expired[`T_UNDERV] |=> !fault_pin_oe_n)
    else $error("Fault not asserted after bus undervoltage blanking.");

  a_uv_soft : assert property (@(posedge clock) disable iff (logic_rst)
    $fell(underv) |=> soft_start)
    else $error("Soft-start did not follow removal of bus undervoltage.");

  a_limit_set_pin_clear : assert property (@(posedge clock) disable iff (logic_rst)
    $fell(set_err) && !hot && !ov_data && !ov_logic && !underv && oc_state != OC_RETRY
    |=> fault_pin_oe_n)
    else $error("Fault not released when limit-set error ended.");

  a_disable_open : assert property (@(posedge clock) disable iff (logic_rst)
    !en_active && !cfg |=> !ext_switch_on && !int_switch_on && !data_switch_on)
    else $error("Switches stayed closed while the port was disabled.");

  a_hs_mode : assert property (@(posedge clock) disable iff (logic_rst)
    en_active && !cfg |=> !charge_detect_enable)
    else $error("Charger detection enabled in plain pass-through mode.");

  // A fresh condition must start from zero, so expiry cannot follow on the next edge.
  a_blank_fresh : assert property (@(posedge clock) disable iff (logic_rst)
    $rose(ov_data) |=> !blank.expired[`T_OV_DATA])
    else $error("Blanking expired at once on a new data-line overvoltage.");
endmodule // usb_port_fault_supervisor
`default_nettype wire

/* File: port_far_side.sv */
/*
  Far side of the supervised port: the host pin that carries enable and the pulled-up
  open-drain fault node. Assumes the supervisor drives fault_pin_out low when enabled.
*/
`timescale 1ns/10ps
`default_nettype none
module port_far_side #(
  parameter bit ENABLE_ACTIVE_LOW = 1'b0
) (
  input  wire logic host_en,
  input  wire logic fault_pin_out,
  input  wire logic fault_pin_oe_n,
  output var  logic enable_in,
  output var  logic fault_wire
);
  // The host speaks of a request; the pin level follows the variant's polarity.
  assign enable_in = ENABLE_ACTIVE_LOW ? ~host_en : host_en;
  // The pull-up holds the node high whenever the supervisor lets go of it.
  assign fault_wire = fault_pin_oe_n ? 1'b1 : fault_pin_out;
endmodule // port_far_side
`default_nettype wire

/* File: usb_port_fault_supervisor_tb.sv */
/*
  Self-checking bench for the port fault supervisor with a short blanking count.
  Assumes the far-side model supplies the enable pin and the pulled-up fault node.
*/
`timescale 1ns/10ps
`default_nettype none
module usb_port_fault_supervisor_tb;
  localparam int N = 20;
  logic       clock   = 1'b0;
  logic       rst     = 1'b1;
  logic [7:0] flt     = 8'h00;
  logic       recov   = 1'b0;
  logic       host_en = 1'b0;
  logic       chg     = 1'b0;
  logic       enable_in, fault_wire, fault_pin_out, fault_pin_oe_n;
  logic       ext_on, int_on, data_on, limit_on, small_on, soft_start, detect_on;
  logic       low_en_pin, low_fault_wire, low_pin_out, low_pin_oe_n;
  logic [2:0] low_sw;
  int         err_total = 0;
  int         checks    = 0;
  int         i;
  int         hold;

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  // Fault vector bits: pos, neg, logic OV, overcurrent, bus UV, lockout, temp, limit set.
  usb_port_fault_supervisor #(.BLANK_CYCLES(N)) usb_port_fault_supervisor_i (
    .clock(clock), .rst(rst), .ov_data_pos(flt[0]), .ov_data_neg(flt[1]),
    .ov_logic_supply(flt[2]), .over_current(flt[3]), .bus_undervolt(flt[4]),
    .supply_lockout(flt[5]), .over_temp(flt[6]), .limit_set_error(flt[7]),
    .out_above_recovery(recov), .enable_in(enable_in), .charge_cfg_bit1(chg),
    .fault_pin_in(fault_wire), .fault_pin_out(fault_pin_out),
    .fault_pin_oe_n(fault_pin_oe_n), .ext_switch_on(ext_on), .int_switch_on(int_on),
    .data_switch_on(data_on), .current_limit_active(limit_on),
    .small_source_on(small_on), .soft_start(soft_start),
    .charge_detect_enable(detect_on));

  port_far_side port_far_side_i (
    .host_en(host_en), .fault_pin_out(fault_pin_out), .fault_pin_oe_n(fault_pin_oe_n),
    .enable_in(enable_in), .fault_wire(fault_wire));

  // The active-low variant sees the same host request through its own pin polarity.
  port_far_side #(.ENABLE_ACTIVE_LOW(1'b1)) port_far_side_low_i (
    .host_en(host_en), .fault_pin_out(low_pin_out), .fault_pin_oe_n(low_pin_oe_n),
    .enable_in(low_en_pin), .fault_wire(low_fault_wire));

  // A generate block lets the second variant keep the usual instance name.
  if (1) begin : g_active_low
    usb_port_fault_supervisor #(.ENABLE_ACTIVE_LOW(1'b1), .BLANK_CYCLES(N))
      usb_port_fault_supervisor_i (
      .clock(clock), .rst(rst), .ov_data_pos(flt[0]), .ov_data_neg(flt[1]),
      .ov_logic_supply(flt[2]), .over_current(flt[3]), .bus_undervolt(flt[4]),
      .supply_lockout(flt[5]), .over_temp(flt[6]), .limit_set_error(flt[7]),
      .out_above_recovery(recov), .enable_in(low_en_pin), .charge_cfg_bit1(chg),
      .fault_pin_in(low_fault_wire), .fault_pin_out(low_pin_out),
      .fault_pin_oe_n(low_pin_oe_n), .ext_switch_on(low_sw[2]), .int_switch_on(low_sw[1]),
      .data_switch_on(low_sw[0]), .current_limit_active(), .small_source_on(),
      .soft_start(), .charge_detect_enable());
  end

  // Switch pattern {ext, int, data} once immediate actions have landed.
  function automatic logic [2:0] exp_sw(input logic [7:0] f);
    logic cut;
    cut = f[0] | f[1] | f[5] | f[6] | f[7];
    return {host_en & ~cut & ~f[2], host_en & ~cut & ~f[4], host_en & ~cut & ~f[2] & ~chg};
  endfunction

  // Faults that pull the node low with no blanking at all.
  function automatic logic fault_now(input logic [7:0] f);
    return f[6] | f[7];
  endfunction

  // Inputs move 1 ns after the edge, so outputs read here are already settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL at %0t: saw %b, expected %b", $time, seen, exp);
    end
  endtask

  task automatic chk_sw(input logic [2:0] exp);
    chk(ext_on, exp[2]);
    chk(int_on, exp[1]);
    chk(data_on, exp[0]);
    chk(low_sw[2], exp[2]);
    chk(low_sw[1], exp[1]);
    chk(low_sw[0], exp[0]);
  endtask

  task automatic conclude();
    $display("Checks made: %0d, mismatches: %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Clear all faults and let any soft-start ramp finish, under a bounded wait.
  task automatic settle();
    int k;
    flt = 8'h00;
    recov = 1'b0;
    cyc(4);
    for (k = 0; k < 1200 && soft_start !== 1'b0; k++) cyc(1);
    if (soft_start !== 1'b0) begin
      err_total++;
      $display("FAIL at %0t: soft-start never ended", $time);
      conclude();
    end
    cyc(2);
  endtask

  initial begin
    hold = $urandom(54);
    cyc(8);
    rst = 1'b0;
    cyc(4);
    chk_sw(3'b000);
    chk(fault_wire, 1'b1);
    host_en = 1'b1;
    cyc(4);
    chk_sw(exp_sw(flt));
    chk(detect_on, 1'b0);
    chg = 1'b1;
    cyc(4);
    chk(detect_on, 1'b1);
    chg = 1'b0;
    cyc(4);
    // Each fault kind alone; overcurrent has its own sequence below.
    for (i = 0; i < 8; i++) begin
      if (i == 3) continue;
      flt = 8'(1 << i);
      cyc(4);
      chk_sw(exp_sw(flt));
      chk(fault_wire, ~fault_now(flt));
      if (i != 5 && !fault_now(flt)) begin
        cyc(N - 6);
        chk(fault_wire, 1'b1);
        cyc(8);
        chk(fault_wire, 1'b0);
      end
      flt = 8'h00;
      cyc(4);
      chk(fault_wire, 1'b1);
      if (i == 0 || i == 1 || i == 4) chk(soft_start, 1'b1);
      settle();
      chk_sw(exp_sw(flt));
    end
    // A spike that drops before expiry must not carry its count into the next one.
    hold = 5 + ($urandom % (N - 8));
    flt = 8'h02;
    cyc(hold);
    flt = 8'h00;
    cyc(4);
    flt = 8'h02;
    cyc(N - 2);
    chk(fault_wire, 1'b1);
    cyc(8);
    chk(fault_wire, 1'b0);
    settle();
    // Overcurrent: limit, thermal cut-off, expiry into autoretry, then recovery.
    flt = 8'h08;
    cyc(4);
    chk(limit_on, 1'b1);
    chk(int_on, 1'b1);
    chk(fault_wire, 1'b1);
    flt = 8'h48;
    cyc(4);
    chk(limit_on, 1'b0);
    chk(fault_wire, 1'b0);
    flt = 8'h08;
    cyc(4);
    chk(limit_on, 1'b1);
    cyc(N - 6);
    chk(small_on, 1'b0);
    chk(fault_wire, 1'b1);
    cyc(10);
    chk(small_on, 1'b1);
    chk(int_on, 1'b0);
    chk(fault_wire, 1'b0);
    flt = 8'h00;
    recov = 1'b1;
    cyc(N - 4);
    chk(small_on, 1'b1);
    cyc(10);
    chk(small_on, 1'b0);
    chk(int_on, 1'b1);
    chk(fault_wire, 1'b1);
    settle();
    // Random back-to-back unblanked faults of random length.
    for (i = 0; i < 6; i++) begin
      flt = ($urandom % 2) ? 8'h40 : 8'h80;
      hold = 4 + ($urandom % 30);
      cyc(hold);
      chk(fault_wire, 1'b0);
      chk_sw(3'b000);
      flt = 8'h00;
      cyc(4);
      chk(fault_wire, 1'b1);
    end
    settle();
    host_en = 1'b0;
    cyc(4);
    chk_sw(3'b000);
    chk(fault_pin_out, 1'b0);
    chk(low_fault_wire, 1'b1);
    conclude();
  end
endmodule // usb_port_fault_supervisor_tb
`default_nettype wire
